// [logic/ddct_map.svh]
// Overview of operation
// - power-up clears sections, divider; enters idle
// - tenth or minute base counts divider ticks
// - external source counts external timer pulses
// - gate low inhibits sections, and divider except with external source
// - remote reset pulse clears sections and divider
// - remote count pulse enters counting condition
// - preset reached gives pulse, counting stops
// - recycling waits dwell, clears, restarts counting
// - dwell-done pulse marks automatic reset
// - interval high only while able to count
// - internal base: time-base out follows ticks
// - external source: free-running tenth-second output
// - timer wrap gives 500 ns overflow pulse
// - counter wrap gives 500 ns overflow pulse
// - timer overflows only with preset off or m above nine
// - each section is eight decimal digits
// - count starts only when not at preset, gate open
// - preset-reached pulse is 5.0 us wide
// - dwell-done pulse is 500 ns wide
`ifndef DDCT_MAP_SVH
`define DDCT_MAP_SVH

// ****************************************
// timing
// ****************************************
`define DDCT_CLK_NS      25
`define DDCT_TENTH_NS    100000000
`define DDCT_MIN_TENTHS  600
`define DDCT_OVF_NS      500
`define DDCT_TBOUT_NS    500
`define DDCT_EOP_NS      5000
`define DDCT_EOD_NS      500

// ****************************************
// sizes and input slots
// ****************************************
`define DDCT_DIGITS      8
`define DDCT_IN_GATE     0
`define DDCT_IN_RST      1
`define DDCT_IN_CNT      2
`define DDCT_IN_STOP     3
`define DDCT_IN_PULSE    4
`define DDCT_IN_EXT      5
`define DDCT_IN_NUM      6

`endif

// [logic/ddct_pkg.sv]
package ddct_pkg;
  typedef enum logic [1:0] {
    DDCT_BASE_TENTH  = 2'h0,
    DDCT_BASE_MINUTE = 2'h1,
    DDCT_BASE_EXT    = 2'h2
  } ddct_base_t;

  // gray along idle -> count -> dwell -> count
  typedef enum logic [1:0] {
    DDCT_ST_IDLE  = 2'h0,
    DDCT_ST_COUNT = 2'h1,
    DDCT_ST_DWELL = 2'h3
  } ddct_state_t;
endpackage : ddct_pkg

// [logic/ddct_bcd_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module ddct_bcd_counter #(
  parameter int unsigned DIGITS = 8
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  clr_in,
  input  wire logic                  inc_in,
  output logic [4*DIGITS-1:0]        count_out,
  output logic                       wrap_out
);
  logic [3:0]    dig_reg [DIGITS];
  logic [DIGITS:0] carry;

  assign carry[0] = inc_in;

  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dig
      assign carry[g+1] = carry[g] && (dig_reg[g] == 4'h9);
      assign count_out[4*g +: 4] = dig_reg[g];
      always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          dig_reg[g] <= 4'h0;
        end else if (clr_in) begin
          dig_reg[g] <= 4'h0;
        end else if (carry[g]) begin
          dig_reg[g] <= (dig_reg[g] == 4'h9) ? 4'h0 : dig_reg[g] + 4'h1;
        end
      end
    end
  endgenerate

  // all nines and stepping: the section rolls over to zero
  assign wrap_out = carry[DIGITS] && !clr_in;
endmodule : ddct_bcd_counter

`default_nettype wire

// [logic/ddct_pulse_gen.sv]
`timescale 1ns/1ps
`default_nettype none

module ddct_pulse_gen #(
  parameter int unsigned WIDTH = 20
) (
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  input  wire logic trig_in,
  output logic      pulse_out
);
  localparam int unsigned CW = $clog2(WIDTH + 1);

  logic [CW-1:0] cnt_reg;
  logic          pulse_reg;

  // retrigger restarts the full width
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= '0;
    end else if (trig_in) begin
      cnt_reg <= CW'(WIDTH);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= trig_in || (cnt_reg > CW'(1));
    end
  end

  assign pulse_out = pulse_reg;
endmodule : ddct_pulse_gen

`default_nettype wire

// [logic/ddct_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ddct_map.svh"

module ddct_top #(
  parameter int unsigned TENTH_CYC = `DDCT_TENTH_NS / `DDCT_CLK_NS,
  parameter int unsigned DWELL_CYC = `DDCT_TENTH_NS / `DDCT_CLK_NS,
  parameter int unsigned DIGITS    = `DDCT_DIGITS
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 gate_in,
  input  wire logic                 remote_reset_in,
  input  wire logic                 remote_count_in,
  input  wire logic                 stop_in,
  input  wire logic                 count_pulse_in,
  input  wire logic                 ext_timer_in,
  input  wire ddct_pkg::ddct_base_t base_sel_in,
  input  wire logic [3:0]           preset_m_in,
  input  wire logic [2:0]           preset_n_in,
  input  wire logic                 dwell_on_in,
  input  wire logic [7:0]           dwell_tenths_in,
  output logic                      interval_out,
  output logic                      preset_reached_pulse_out,
  output logic                      dwell_done_pulse_out,
  output logic                      time_base_out,
  output logic                      timer_ovf_out,
  output logic                      counter_ovf_out,
  output logic [4*DIGITS-1:0]       timer_count_out,
  output logic [4*DIGITS-1:0]       counter_count_out
);
  import ddct_pkg::*;

  // ****************************************
  // constants
  // ****************************************
  localparam int unsigned OVF_CYC =
    (`DDCT_OVF_NS + `DDCT_CLK_NS - 1) / `DDCT_CLK_NS;
  localparam int unsigned TBO_CYC =
    (`DDCT_TBOUT_NS + `DDCT_CLK_NS - 1) / `DDCT_CLK_NS;
  localparam int unsigned EOP_CYC =
    (`DDCT_EOP_NS + `DDCT_CLK_NS - 1) / `DDCT_CLK_NS;
  localparam int unsigned EOD_CYC =
    (`DDCT_EOD_NS + `DDCT_CLK_NS - 1) / `DDCT_CLK_NS;
  localparam int unsigned CW    = 4 * DIGITS;
  localparam int unsigned DIV_W = $clog2(TENTH_CYC);
  localparam int unsigned MIN_W = $clog2(`DDCT_MIN_TENTHS);
  localparam int unsigned DWP_W = $clog2(DWELL_CYC);
  localparam int unsigned NIN   = `DDCT_IN_NUM;

  // preset = m * 10^n as a bcd word
  function automatic logic [CW-1:0] preset_bcd(input logic [3:0] m,
                                               input logic [2:0] n);
    logic [CW-1:0] v;
    v = '0;
    v[4*n +: 4] = m;
    return v;
  endfunction : preset_bcd

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [NIN-1:0] raw_pins;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;

  assign raw_pins[`DDCT_IN_GATE]  = gate_in;
  assign raw_pins[`DDCT_IN_RST]   = remote_reset_in;
  assign raw_pins[`DDCT_IN_CNT]   = remote_count_in;
  assign raw_pins[`DDCT_IN_STOP]  = stop_in;
  assign raw_pins[`DDCT_IN_PULSE] = count_pulse_in;
  assign raw_pins[`DDCT_IN_EXT]   = ext_timer_in;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= raw_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  logic gate_s;
  logic stop_s;
  logic rst_edge;
  logic cnt_edge;
  logic pulse_edge;
  logic ext_edge;

  // edges use stages two and three only
  assign gate_s     = s2_reg[`DDCT_IN_GATE];
  assign stop_s     = s2_reg[`DDCT_IN_STOP];
  assign rst_edge   = s2_reg[`DDCT_IN_RST] && !s3_reg[`DDCT_IN_RST];
  assign cnt_edge   = s2_reg[`DDCT_IN_CNT] && !s3_reg[`DDCT_IN_CNT];
  assign pulse_edge = s2_reg[`DDCT_IN_PULSE] && !s3_reg[`DDCT_IN_PULSE];
  assign ext_edge   = s2_reg[`DDCT_IN_EXT] && !s3_reg[`DDCT_IN_EXT];

  // ****************************************
  // counting condition
  // ****************************************
  ddct_state_t   state_reg;
  ddct_state_t   state_next;
  logic          is_ext;
  logic          is_min;
  logic          at_preset;
  logic          count_en;
  logic          dwell_evt;
  logic          preset_evt;
  logic          clr_all;
  logic [CW-1:0] tmr_cnt;
  logic [CW-1:0] ctr_cnt;

  assign is_ext = (base_sel_in == DDCT_BASE_EXT);
  assign is_min = (base_sel_in == DDCT_BASE_MINUTE);

  // m of zero switches preset off; m of one to nine keeps the preset below the
  // top count, so the timer stops there before it can wrap; m above nine never matches
  assign at_preset = (preset_m_in != 4'h0) &&
                     (tmr_cnt == preset_bcd(preset_m_in, preset_n_in));

  assign count_en   = (state_reg == DDCT_ST_COUNT) && gate_s && !at_preset;
  assign preset_evt = (state_reg == DDCT_ST_COUNT) && !stop_s && at_preset;
  assign clr_all    = rst_edge || dwell_evt;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DDCT_ST_IDLE: begin
        if (cnt_edge && !at_preset && gate_s) begin
          state_next = DDCT_ST_COUNT;
        end
      end
      DDCT_ST_COUNT: begin
        if (stop_s) begin
          state_next = DDCT_ST_IDLE;
        end else if (at_preset) begin
          state_next = dwell_on_in ? DDCT_ST_DWELL : DDCT_ST_IDLE;
        end
      end
      DDCT_ST_DWELL: begin
        if (stop_s || rst_edge) begin
          state_next = DDCT_ST_IDLE;
        end else if (dwell_evt) begin
          state_next = DDCT_ST_COUNT;
        end
      end
      default: begin
        state_next = DDCT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= DDCT_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // dwell timer
  // ****************************************
  logic [DWP_W-1:0] dw_pre_reg;
  logic [7:0]       dw_ten_reg;

  // stop or reset during dwell abandons the recycle
  assign dwell_evt = (state_reg == DDCT_ST_DWELL) && !stop_s && !rst_edge &&
                     (dw_ten_reg >= dwell_tenths_in);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dw_pre_reg <= '0;
      dw_ten_reg <= 8'h00;
    end else if (state_reg != DDCT_ST_DWELL) begin
      dw_pre_reg <= '0;
      dw_ten_reg <= 8'h00;
    end else if (dw_pre_reg == DWP_W'(DWELL_CYC - 1)) begin
      dw_pre_reg <= '0;
      dw_ten_reg <= (dw_ten_reg == 8'hFF) ? dw_ten_reg : dw_ten_reg + 8'h01;
    end else begin
      dw_pre_reg <= dw_pre_reg + DWP_W'(1);
    end
  end

  // ****************************************
  // time-base divider
  // ****************************************
  logic [DIV_W-1:0] div_reg;
  logic [MIN_W-1:0] min_reg;
  logic             div_run;
  logic             tenth_tick;
  logic             min_tick;
  logic             tmr_inc;
  logic             tb_trig;

  // external mode keeps the divider free-running for the output
  assign div_run    = is_ext || count_en;
  assign tenth_tick = div_run && (div_reg == DIV_W'(TENTH_CYC - 1));
  assign min_tick   = tenth_tick &&
                      (min_reg == MIN_W'(`DDCT_MIN_TENTHS - 1));

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_reg <= '0;
    end else if (clr_all) begin
      div_reg <= '0;
    end else if (div_run) begin
      div_reg <= tenth_tick ? '0 : div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      min_reg <= '0;
    end else if (clr_all) begin
      min_reg <= '0;
    end else if (tenth_tick) begin
      min_reg <= min_tick ? '0 : min_reg + MIN_W'(1);
    end
  end

  assign tmr_inc = count_en && (is_ext ? ext_edge :
                               (is_min ? min_tick : tenth_tick));
  assign tb_trig = is_ext ? tenth_tick : tmr_inc;

  // ****************************************
  // counting sections
  // ****************************************
  logic tmr_wrap;
  logic ctr_wrap;

  ddct_bcd_counter #(.DIGITS(DIGITS)) u_timer (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .clr_in     (clr_all),
    .inc_in     (tmr_inc),
    .count_out  (tmr_cnt),
    .wrap_out   (tmr_wrap)
  );

  ddct_bcd_counter #(.DIGITS(DIGITS)) u_counter (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .clr_in     (clr_all),
    .inc_in     (count_en && pulse_edge),
    .count_out  (ctr_cnt),
    .wrap_out   (ctr_wrap)
  );

  assign timer_count_out   = tmr_cnt;
  assign counter_count_out = ctr_cnt;

  // ****************************************
  // output pulses
  // ****************************************
  ddct_pulse_gen #(.WIDTH(EOP_CYC)) u_eop (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .trig_in    (preset_evt),
    .pulse_out  (preset_reached_pulse_out)
  );

  ddct_pulse_gen #(.WIDTH(EOD_CYC)) u_eod (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .trig_in    (dwell_evt),
    .pulse_out  (dwell_done_pulse_out)
  );

  ddct_pulse_gen #(.WIDTH(TBO_CYC)) u_tbo (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .trig_in    (tb_trig),
    .pulse_out  (time_base_out)
  );

  ddct_pulse_gen #(.WIDTH(OVF_CYC)) u_tovf (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .trig_in    (tmr_wrap),
    .pulse_out  (timer_ovf_out)
  );

  ddct_pulse_gen #(.WIDTH(OVF_CYC)) u_covf (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .trig_in    (ctr_wrap),
    .pulse_out  (counter_ovf_out)
  );

  logic interval_reg;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interval_reg <= 1'b0;
    end else begin
      interval_reg <= count_en;
    end
  end

  assign interval_out = interval_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  logic [7:0] eop_hi_reg;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      eop_hi_reg <= 8'h00;
    end else if (preset_reached_pulse_out) begin
      eop_hi_reg <= eop_hi_reg + 8'h01;
    end else begin
      eop_hi_reg <= 8'h00;
    end
  end

  reset_clears_a: assert property (rst_edge |=>
    tmr_cnt == '0 && ctr_cnt == '0 && div_reg == '0)
    else $error("remote reset did not clear the sections");
  gate_blocks_a: assert property (!gate_s && !clr_all |=> !interval_out &&
    $stable(tmr_cnt) && $stable(ctr_cnt))
    else $error("counting went on while gate held low");
  start_refused_a: assert property (
    state_reg == DDCT_ST_IDLE && cnt_edge && (at_preset || !gate_s)
    |=> state_reg == DDCT_ST_IDLE)
    else $error("count command accepted at preset or gate low");
  preset_stops_a: assert property (preset_evt |=>
    state_reg != DDCT_ST_COUNT ##1 preset_reached_pulse_out)
    else $error("preset reached without stop or pulse");
  eop_width_a: assert property ($fell(preset_reached_pulse_out) |->
    $past(eop_hi_reg) == 8'(EOP_CYC - 1))
    else $error("preset pulse width wrong");
  dwell_restart_a: assert property (dwell_evt |=>
    dwell_done_pulse_out && state_reg == DDCT_ST_COUNT && tmr_cnt == '0)
    else $error("dwell end did not restart cleanly");
  eod_width_a: assert property ($rose(dwell_done_pulse_out) |->
    ##19 dwell_done_pulse_out ##1 !dwell_done_pulse_out)
    else $error("dwell pulse width wrong");
  ctr_ovf_a: assert property (ctr_wrap |=> ctr_cnt == '0 ##1
    counter_ovf_out [*8])
    else $error("counter wrap without overflow pulse");
  tbo_ext_a: assert property (is_ext && tenth_tick && !clr_all |=>
    time_base_out && div_reg == '0)
    else $error("free-running time base missing");
  ext_counts_a: assert property (
    is_ext && ext_edge && count_en && !clr_all |=> $changed(tmr_cnt))
    else $error("external pulse not counted");
  preset_off_a: assert property (preset_m_in == 4'h0 && !stop_s &&
    state_reg == DDCT_ST_COUNT |=> state_reg == DDCT_ST_COUNT)
    else $error("counting stopped with preset off");

  preset_hit_c: cover property (preset_evt);
  dwell_done_c: cover property (dwell_evt);
  ctr_ovf_c:    cover property (ctr_wrap);
  ext_count_c:  cover property (is_ext && tmr_inc);
endmodule : ddct_top

`default_nettype wire

// [tb/ddct_pulse_src.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// pulse sources and downstream stage
// ****************************************
module ddct_pulse_src (
  input  wire logic clk_sys_in,
  input  wire logic ovf_in,
  output logic      count_pulse_out,
  output logic      ext_pulse_out
);
  int unsigned ovf_seen;
  logic        ovf_d;

  initial begin
    count_pulse_out = 1'b0;
    ext_pulse_out   = 1'b0;
    ovf_seen        = 0;
    ovf_d           = 1'b0;
  end

  // overflow rising edges are counted in ovf_seen as a further stage
  always @(posedge clk_sys_in) begin
    ovf_d <= ovf_in;
    if (ovf_in && !ovf_d) begin
      ovf_seen <= ovf_seen + 1;
    end
  end

  // high two cycles, low at least gap+1: the sync needs a low between edges
  task automatic send(input bit ext, input int n, input int gap);
    repeat (n) begin
      @(negedge clk_sys_in);
      if (ext) ext_pulse_out = 1'b1;
      else count_pulse_out = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      count_pulse_out = 1'b0;
      ext_pulse_out   = 1'b0;
      repeat (gap) @(negedge clk_sys_in);
    end
  endtask : send
endmodule : ddct_pulse_src

`default_nettype wire

// [tb/dual_decade_counter_timer_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module dual_decade_counter_timer_bench;
  import ddct_pkg::*;

  localparam int unsigned TCYC = 40;
  localparam int unsigned DIG  = 2;

  logic             clk, arst_n, gate, rst_cmd, cnt_cmd, stop, cpulse, epulse;
  logic             dwell_on, intv, eop, eod, tb, tovf, covf;
  ddct_base_t       base_sel;
  logic [3:0]       pm;
  logic [2:0]       pn;
  logic [7:0]       dwell_t;
  logic [4*DIG-1:0] tcnt, ccnt;
  logic [31:0]      lfsr_reg;
  int               n_mismatch   = 0;
  int               total_checks = 0;

  ddct_top #(.TENTH_CYC(TCYC), .DWELL_CYC(10), .DIGITS(DIG)) dut (
    .clk_sys_in(clk), .arst_n_in(arst_n), .gate_in(gate), .remote_reset_in(rst_cmd),
    .remote_count_in(cnt_cmd), .stop_in(stop), .count_pulse_in(cpulse),
    .ext_timer_in(epulse), .base_sel_in(base_sel), .preset_m_in(pm), .preset_n_in(pn),
    .dwell_on_in(dwell_on), .dwell_tenths_in(dwell_t), .interval_out(intv),
    .preset_reached_pulse_out(eop), .dwell_done_pulse_out(eod), .time_base_out(tb),
    .timer_ovf_out(tovf), .counter_ovf_out(covf), .timer_count_out(tcnt),
    .counter_count_out(ccnt));

  ddct_pulse_src src (.clk_sys_in(clk), .ovf_in(covf), .count_pulse_out(cpulse),
    .ext_pulse_out(epulse));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [4*DIG-1:0] bcd(input int v);
    logic [4*DIG-1:0] r;
    for (int i = 0; i < DIG; i++) begin
      r[4*i +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction : bcd

  function automatic void rnd(input int lim, output int v);
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    v = int'(lfsr_reg % lim);
  endfunction : rnd

  function automatic logic pick(input int k);
    case (k)
      0: return eop;
      1: return eod;
      2: return tb;
      3: return tovf;
      default: return covf;
    endcase
  endfunction : pick

  task automatic wait_rise(input int k, input int lim, output int w);
    logic prev;
    prev = pick(k);
    for (w = 1; w <= lim; w++) begin
      @(negedge clk);
      if (pick(k) === 1'b1 && prev !== 1'b1) break;
      prev = pick(k);
    end
  endtask : wait_rise

  task automatic high_width(input int k, output int w);
    w = 0;
    while (pick(k) === 1'b1 && w < 1000) begin
      @(negedge clk);
      w++;
    end
  endtask : high_width

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic strobe(input bit rst);
    @(negedge clk);
    if (rst) rst_cmd = 1'b1;
    else cnt_cmd = 1'b1;
    repeat (4) @(negedge clk);
    rst_cmd = 1'b0;
    cnt_cmd = 1'b0;
    repeat (8) @(negedge clk);
  endtask : strobe

  task automatic restart();
    stop = 1'b1;
    repeat (4) @(negedge clk);
    stop = 1'b0;
    strobe(1'b1);
    strobe(1'b0);
  endtask : restart

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    int               n, g, w, wd, m, e;
    logic [4*DIG-1:0] snap;
    lfsr_reg = 32'h00007F26;
    {arst_n, rst_cmd, cnt_cmd, stop, dwell_on} = 5'h00;
    gate     = 1'b1;
    base_sel = DDCT_BASE_TENTH;
    pm       = 4'h0;
    pn       = 3'h0;
    dwell_t  = 8'h03;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    check({intv, eop, eod, tb, tovf, covf}, 0);
    check({tcnt, ccnt}, 0);
    $display("test reset done");
    strobe(1'b0);
    check(intv, 1);
    strobe(1'b1);
    check({tcnt, ccnt}, 0);
    rnd(40, n);
    n++;
    rnd(3, g);
    src.send(1'b0, n, g + 2);
    repeat (6) @(negedge clk);
    check(ccnt, bcd(n));
    gate = 1'b0;
    repeat (6) @(negedge clk);
    snap = tcnt;
    src.send(1'b0, 5, 2);
    repeat (50) @(negedge clk);
    check(ccnt, bcd(n));
    check(tcnt, snap);
    check(intv, 0);
    gate = 1'b1;
    repeat (6) @(negedge clk);
    check(intv, 1);
    $display("test count and gate done");
    strobe(1'b1);
    fork
      src.send(1'b0, 100, 2);
      begin
        wait_rise(4, 1000, w);
        high_width(4, wd);
      end
    join
    repeat (6) @(negedge clk);
    check(w <= 1000, 1);
    check(wd, 20);
    check(ccnt, 0);
    check(src.ovf_seen, 1);
    wait_rise(2, 100, w);
    wait_rise(2, 100, w);
    check(w, TCYC);
    wait_rise(3, 4200, w);
    high_width(3, wd);
    check(w <= 4200, 1);
    check(wd, 20);
    check(tcnt, 0);
    stop = 1'b1;
    repeat (6) @(negedge clk);
    check(intv, 0);
    $display("test overflow done");
    for (int i = 0; i < 3; i++) begin
      rnd(9, m);
      m++;
      rnd(2, e);
      pm = 4'(m);
      pn = 3'(e);
      restart();
      wait_rise(0, 4000, w);
      check(w <= 4000, 1);
      check(tcnt, bcd(e ? m * 10 : m));
      high_width(0, wd);
      check(wd, 200);
      check(intv, 0);
      check(tcnt, bcd(e ? m * 10 : m));
      strobe(1'b0);
      check(intv, 0);
    end
    $display("test preset done");
    pm       = 4'h2;
    pn       = 3'h0;
    dwell_on = 1'b1;
    // dwell plus preset must outlast the 200-cycle preset pulse
    dwell_t  = 8'h0F;
    restart();
    src.send(1'b0, 3, 2);
    wait_rise(0, 200, w);
    wait_rise(1, 200, w);
    check(w <= 200, 1);
    check({tcnt, ccnt}, 0);
    high_width(1, wd);
    check(wd, 20);
    check(intv, 1);
    wait_rise(0, 200, w);
    check(w <= 200, 1);
    dwell_on = 1'b0;
    pm       = 4'h0;
    $display("test dwell done");
    stop = 1'b1;
    repeat (4) @(negedge clk);
    base_sel = DDCT_BASE_MINUTE;
    restart();
    wait_rise(2, 25000, w);
    repeat (2) @(negedge clk);
    check(w >= 600 * TCYC - 40 && w <= 600 * TCYC, 1);
    check(tcnt, bcd(1));
    stop = 1'b1;
    repeat (4) @(negedge clk);
    base_sel = DDCT_BASE_EXT;
    restart();
    rnd(40, n);
    n++;
    src.send(1'b1, n, 3);
    repeat (6) @(negedge clk);
    check(tcnt, bcd(n));
    gate = 1'b0;
    repeat (6) @(negedge clk);
    wait_rise(2, 100, w);
    wait_rise(2, 100, w);
    check(w, TCYC);
    gate = 1'b1;
    $display("test time base done");
    finish_test();
  end
endmodule : dual_decade_counter_timer_bench

`default_nettype wire
